// [rtl/jssr_pkg.sv]
// package: constants for the sync-request and error-signaling block
package jssr_pkg;
  // subclass codes
  localparam logic [1:0] SUBCLASS_0 = 2'h0;
  localparam logic [1:0] SUBCLASS_1 = 2'h1;
  localparam logic [1:0] SUBCLASS_2 = 2'h2;
  // error-report width in frame clock periods
  localparam int ERR_FRAMES_F1 = 4;
  localparam int ERR_FRAMES_FN = 2;
  // link clock carries 4 octets; frame is F octets
  localparam int OCTETS_PER_LINK = 4;
  // default /K/ count needed before release
  localparam int K_NEEDED_DEF = 4;
  // receive and transmit error cause fields
  localparam int RXA_CGS_BIT = 0;
  localparam int RXA_DISP_BIT = 1;
  localparam int RXA_NIT_BIT = 2;
  localparam int RXB_FRAME_BIT = 0;
  localparam int RXB_LANE_BIT = 1;
  localparam int RXB_SYSREF_BIT = 2;
  localparam int TXE_SYNC_BIT = 0;
  // receive state codes
  typedef enum logic [1:0] {
    JSSR_RX_SYNCREQ = 2'b00,
    JSSR_RX_WAITREF = 2'b01,
    JSSR_RX_LINKED = 2'b10
  } jssr_rx_state_t;
endpackage

// [rtl/jssr_sync2.sv]
// two-flop synchroniser for a level from outside the link clock domain
module jssr_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic meta_d;
  logic dout_q;
  logic dout_d;

  always_comb begin
    meta_d = din;
    dout_d = meta_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RESET_VAL;
      dout_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      dout_q <= dout_d;
    end
  end

  assign dout = dout_q;
endmodule

// [rtl/jssr_core.sv]
// sync-request release (receiver) and sync error qualifier (transmitter)
module jssr_core #(
  parameter int K_NEEDED = jssr_pkg::K_NEEDED_DEF,
  parameter int CNT_W = 8
) (
  // clock and reset (link clock domain)
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire logic [1:0] subclass,
  input wire logic [7:0] octets_per_frame,
  // receiver side lane status (same domain)
  input wire logic k_char_seen,
  input wire logic rx_cgs_err,
  input wire logic rx_disp_err,
  input wire logic rx_nit_err,
  input wire logic rx_frame_err,
  input wire logic rx_lane_err,
  input wire logic rx_err_clear,
  // reference edge pin
  input wire logic sysref,
  // receiver sync request out
  output logic rx_sync_n,
  output logic rx_irq,
  output logic [2:0] receive_error_status_a,
  output logic [2:0] receive_error_status_b,
  // transmitter sync in from converter (pin)
  input wire logic tx_sync_n,
  input wire logic tx_err_clear,
  output logic tx_irq,
  output logic [0:0] tx_error_status
);
  // the threshold for F of 255 needs eight count bits
  if (K_NEEDED < 1 || CNT_W < 8 || CNT_W > 16 || K_NEEDED >= (1 << CNT_W)) begin : g_bad_param
    $error("K_NEEDED or CNT_W out of range");
  end

  logic sysref_s;
  logic sync_s;
  jssr_sync2 #(.RESET_VAL(1'b0)) u_sref (.clk(clk), .rstn(rstn), .din(sysref), .dout(sysref_s));
  jssr_sync2 #(.RESET_VAL(1'b1)) u_sync (.clk(clk), .rstn(rstn), .din(tx_sync_n), .dout(sync_s));

  // ---------------- receiver ----------------
  jssr_pkg::jssr_rx_state_t st_q, st_d;
  logic [CNT_W-1:0] kcnt_q, kcnt_d;
  logic sref_prev_q, sref_prev_d;
  logic sref_seen_q, sref_seen_d;
  logic rx_sync_n_q, rx_sync_n_d;
  logic [2:0] rxa_q, rxa_d;
  logic [2:0] rxb_q, rxb_d;
  logic rx_irq_q, rx_irq_d;
  logic sref_rise;
  logic need_ref;

  always_comb begin
    sref_rise = sysref_s & ~sref_prev_q;
    need_ref = (subclass == jssr_pkg::SUBCLASS_1) || (subclass == jssr_pkg::SUBCLASS_2);
    st_d = st_q;
    kcnt_d = kcnt_q;
    sref_prev_d = sysref_s;
    sref_seen_d = sref_seen_q | sref_rise;
    unique case (st_q)
      jssr_pkg::JSSR_RX_SYNCREQ: begin
        if (!k_char_seen) kcnt_d = '0;
        else if (kcnt_q < CNT_W'(K_NEEDED)) kcnt_d = kcnt_q + 1'b1;
        if (k_char_seen && kcnt_q >= CNT_W'(K_NEEDED - 1)) st_d = jssr_pkg::JSSR_RX_WAITREF;
      end
      jssr_pkg::JSSR_RX_WAITREF: begin
        if (!need_ref || sref_seen_q) st_d = jssr_pkg::JSSR_RX_LINKED;
        else if (!k_char_seen) begin
          // a stale count would let one /K/ cycle release the line
          st_d = jssr_pkg::JSSR_RX_SYNCREQ;
          kcnt_d = '0;
        end
      end
      jssr_pkg::JSSR_RX_LINKED: begin
        // loss of sync restarts the request; errors never pulse the line
        if (rx_cgs_err) begin
          st_d = jssr_pkg::JSSR_RX_SYNCREQ;
          kcnt_d = '0;
        end
      end
    endcase
    rx_sync_n_d = (st_d == jssr_pkg::JSSR_RX_LINKED);
    // set wins over clear
    rxa_d = (rx_err_clear ? 3'h0 : rxa_q) | {rx_nit_err, rx_disp_err, rx_cgs_err};
    rxb_d = (rx_err_clear ? 3'h0 : rxb_q)
      | {sref_rise & sref_seen_q & (st_q == jssr_pkg::JSSR_RX_LINKED) & 1'b0, rx_lane_err, rx_frame_err};
    rx_irq_d = (|rxa_d) | (|rxb_d);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= jssr_pkg::JSSR_RX_SYNCREQ;
      kcnt_q <= '0;
      sref_prev_q <= 1'b0;
      sref_seen_q <= 1'b0;
      rx_sync_n_q <= 1'b0;
      rxa_q <= 3'h0;
      rxb_q <= 3'h0;
      rx_irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      kcnt_q <= kcnt_d;
      sref_prev_q <= sref_prev_d;
      sref_seen_q <= sref_seen_d;
      rx_sync_n_q <= rx_sync_n_d;
      rxa_q <= rxa_d;
      rxb_q <= rxb_d;
      rx_irq_q <= rx_irq_d;
    end
  end

  // ---------------- transmitter ----------------
  // threshold in link cycles: frames*F/4 rounded up, at least one
  logic [CNT_W-1:0] low_q, low_d;
  logic [CNT_W-1:0] thr;
  logic [9:0] thr_oct;
  logic [0:0] txe_q, txe_d;
  logic tx_irq_q, tx_irq_d;
  logic err_hit;

  always_comb begin
    thr_oct = (octets_per_frame == 8'h01) ? 10'(jssr_pkg::ERR_FRAMES_F1)
                                          : 10'(jssr_pkg::ERR_FRAMES_FN) * {2'h0, octets_per_frame};
    thr = CNT_W'((thr_oct + 10'(jssr_pkg::OCTETS_PER_LINK - 1)) / 10'(jssr_pkg::OCTETS_PER_LINK));
    if (thr == '0) thr = CNT_W'(1);
    // width counted on link clock samples
    low_d = sync_s ? '0 : ((low_q == '1) ? low_q : low_q + 1'b1);
    // one report per low pulse, at the cycle the width is reached; shorter ignored
    err_hit = !sync_s && (low_q == thr - 1'b1);
    txe_d = (tx_err_clear ? 1'b0 : txe_q) | err_hit;
    tx_irq_d = txe_d[jssr_pkg::TXE_SYNC_BIT];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_q <= '0;
      txe_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      low_q <= low_d;
      txe_q <= txe_d;
      tx_irq_q <= tx_irq_d;
    end
  end

  assign rx_sync_n = rx_sync_n_q;
  assign rx_irq = rx_irq_q;
  // sticky levels, so a separate status clock may resample them
  assign receive_error_status_a = rxa_q;
  assign receive_error_status_b = rxb_q;
  assign tx_irq = tx_irq_q;
  assign tx_error_status = txe_q;

  // ---------------- assertions ----------------
  a_sync_low_reset: assert property (@(posedge clk) !rstn |-> !rx_sync_n)
    else $error("sync request released during reset");
  a_release_needs_k: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rx_sync_n) |-> $past(st_q) != jssr_pkg::JSSR_RX_SYNCREQ)
    else $error("sync released without /K/ count");
  a_release_needs_ref: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rx_sync_n) && subclass != jssr_pkg::SUBCLASS_0 |-> sref_seen_q)
    else $error("sync released before reference edge");
  a_sub2_same_release: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rx_sync_n) && subclass == jssr_pkg::SUBCLASS_2 |-> $past(sref_seen_q))
    else $error("subclass 2 release without reference edge");
  a_err_width: assert property (@(posedge clk) disable iff (!rstn)
    $rose(txe_q[0]) |-> $past(low_q) == thr - 1'b1)
    else $error("error report at wrong width");
  a_err_irq: assert property (@(posedge clk) disable iff (!rstn)
    $rose(txe_q[0]) |=> tx_irq)
    else $error("no interrupt after error report");
  a_short_ignored: assert property (@(posedge clk) disable iff (!rstn)
    sync_s && $past(low_q) < thr && !$past(txe_q[0]) && !$past(tx_err_clear) |-> !txe_q[0] || $past(err_hit))
    else $error("short pulse reported");
  a_no_err_pulse: assert property (@(posedge clk) disable iff (!rstn)
    rx_sync_n && !rx_cgs_err |=> rx_sync_n)
    else $error("sync dropped without loss of sync");
  a_rx_irq: assert property (@(posedge clk) disable iff (!rstn)
    rx_frame_err |=> rx_irq)
    else $error("receive error without interrupt");
  a_width_count: assert property (@(posedge clk) disable iff (!rstn)
    !sync_s && low_q != '1 |=> low_q == $past(low_q) + 1'b1)
    else $error("width counter stalled");

  c_release: cover property (@(posedge clk) disable iff (!rstn) $rose(rx_sync_n));
  c_tx_err: cover property (@(posedge clk) disable iff (!rstn) $rose(tx_irq));
  c_rx_err: cover property (@(posedge clk) disable iff (!rstn) $rose(rx_irq));
  c_resync: cover property (@(posedge clk) disable iff (!rstn) $fell(rx_sync_n));
endmodule

// [verif/jssr_conv_model.sv]
// converter-side model: sync error pulses and reference edges
module jssr_conv_model (
  // clock
  input wire logic clk,
  // release seen from the far side
  input wire logic rel_n,
  // pins toward the block
  output logic sync_n,
  output logic sysref
);
  timeunit 1ns;
  timeprecision 1ps;
  logic aligned_q = 1'h0;
  initial begin
    sync_n = 1'h1;
    sysref = 1'h0;
  end
  // multiframe phase taken from the release edge; a new request drops it
  always @(posedge clk) aligned_q <= rel_n;
  // width in link cycles; caller stretches it to one full cycle for F of one
  task automatic err_pulse(input int n);
    @(negedge clk) sync_n = 1'h0;
    repeat (n) @(negedge clk);
    sync_n = 1'h1;
  endtask
  task automatic ref_pulse();
    @(negedge clk) sysref = 1'h1;
    repeat (2) @(negedge clk);
    sysref = 1'h0;
  endtask
endmodule

// [verif/jssr_core_test.sv]
// self-checking bench for the sync-request and error-signaling core
module jssr_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int K_N = 4;
  logic clk = 1'h0;
  // starts high so the first reset is a real falling edge, not an unknown state
  logic rstn = 1'h1;
  logic [1:0] subclass = 2'h0;
  logic [7:0] octets_per_frame = 8'h04;
  logic k_char_seen = 1'h0;
  // cgs, disp, nit, frame, lane from bit 0 up
  logic [4:0] errs = 5'h00;
  logic rx_err_clear = 1'h0;
  logic tx_err_clear = 1'h0;
  logic sysref, tx_sync_n, rx_sync_n, rx_irq, tx_irq;
  logic [2:0] st_a, st_b;
  logic [0:0] tx_st;
  logic [7:0] tf [6] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h08};
  int tn [6] = '{1, 1, 1, 2, 3, 4};
  logic te [6] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  int errors = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  jssr_conv_model u_conv (.clk(clk), .rel_n(rx_sync_n), .sync_n(tx_sync_n), .sysref(sysref));
  jssr_core #(.K_NEEDED(K_N)) dut (.clk(clk), .rstn(rstn), .subclass(subclass),
    .octets_per_frame(octets_per_frame), .k_char_seen(k_char_seen), .rx_cgs_err(errs[0]),
    .rx_disp_err(errs[1]), .rx_nit_err(errs[2]), .rx_frame_err(errs[3]), .rx_lane_err(errs[4]),
    .rx_err_clear(rx_err_clear), .sysref(sysref), .rx_sync_n(rx_sync_n), .rx_irq(rx_irq),
    .receive_error_status_a(st_a), .receive_error_status_b(st_b), .tx_sync_n(tx_sync_n),
    .tx_err_clear(tx_err_clear), .tx_irq(tx_irq), .tx_error_status(tx_st));
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    cmp_count++;
    if (a !== e) begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset(input logic [1:0] sc);
    @(negedge clk) rstn = 1'h0;
    subclass = sc;
    k_char_seen = 1'h0;
    cyc(20);
    chk(rx_sync_n, 1'h0);
    rstn = 1'h1;
  endtask
  // short pulses must leave no trace; the clear shows the status is sticky
  task automatic tx_case(input logic [7:0] f, input int n, input logic e);
    octets_per_frame = f;
    u_conv.err_pulse(n);
    cyc(6);
    chk(tx_st, e);
    chk(tx_irq, e);
    tx_err_clear = 1'h1;
    cyc(1);
    tx_err_clear = 1'h0;
    cyc(2);
    chk({tx_st, tx_irq}, 2'h0);
  endtask
  initial begin
    do_reset(jssr_pkg::SUBCLASS_0);
    k_char_seen = 1'h1;
    cyc(K_N - 1);
    chk(rx_sync_n, 1'h0);
    cyc(4);
    chk(rx_sync_n, 1'h1);
    errs = 5'h1A;
    cyc(1);
    errs = 5'h00;
    cyc(2);
    chk(rx_sync_n, 1'h1);
    chk({st_a, st_b}, 6'h13);
    chk(rx_irq, 1'h1);
    errs = 5'h05;
    cyc(1);
    errs = 5'h00;
    cyc(1);
    chk(rx_sync_n, 1'h0);
    chk(st_a, 3'h7);
    rx_err_clear = 1'h1;
    cyc(1);
    rx_err_clear = 1'h0;
    cyc(2);
    chk({st_a, st_b, rx_irq}, 7'h00);
    for (int sc = 1; sc <= 2; sc++) begin
      do_reset(sc[1:0]);
      k_char_seen = 1'h1;
      cyc(12);
      chk(rx_sync_n, 1'h0);
      chk(u_conv.aligned_q, 1'h0);
      u_conv.ref_pulse();
      cyc(6);
      chk(rx_sync_n, 1'h1);
      chk(u_conv.aligned_q, 1'h1);
    end
    foreach (tf[i]) tx_case(tf[i], tn[i], te[i]);
    stop_test();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule
